/* File: src/e1tom_tx_overhead_mux.sv */
// Purpose: Chooses frame timing and the source of every overhead bit in outbound E1 frames.
// Assumes: Serial clock, sync and data pins come from another clock and are sampled here.
// Notes:   One outbound word per rising serial clock edge, except while waiting for the first system sync, goes through a two-entry buffer.
module e1tom_tx_overhead_mux
  import e1tom_pkg::*;
(
  input  wire logic              core_clk,
  input  wire logic              rst,
  input  wire logic [ADDR_W-1:0] regAddr,
  input  wire logic [7:0]        regWrData,
  input  wire logic              regWr,
  input  wire logic              regRd,
  output logic      [7:0]        regRdData,
  input  wire logic              tx_serial_clock_pin,
  input  wire logic              tx_serial_data_pin,
  input  wire logic              tx_frame_sync_pin,
  input  wire logic              tx_multiframe_sync_pin,
  output logic                   frameSyncOut,
  output logic                   frameSyncOe,
  output logic                   mfSyncOut,
  output logic                   mfSyncOe,
  input  wire logic              crcMfEnable,
  input  wire logic              hdlcBit,
  input  wire logic              overheadBit,
  output logic                   txBitValid,
  output logic [BUF_W-1:0]       txBitWord,
  input  wire logic              txBitReady
);

  logic [7:0]    select_q;
  logic          overflow_q;
  logic [7:0]    rdData_q;
  logic [3:0]    pinA_q, pinB_q, pinC_q, pinS_q;
  logic          clkEdge;
  logic [7:0]    bitIdx_q, bitIdx_d;
  logic [3:0]    frameIdx_q, frameIdx_d;
  e1tom_timing_e timing_q;
  logic          active;
  logic          serBit, fSync, mfSync, sysTimed;
  logic          outBit;
  logic [3:0]    crc_q, crcSend_q;
  logic          pushValid_q;
  logic [BUF_W-1:0] pushData_q;
  logic          syncOe_q, fSyncOut_q, mfSyncOut_q;
  e1tom_buf_if #(.W(BUF_W)) bufBus ();

  function automatic logic [3:0] crcStep(input logic [3:0] c, input logic b);
    crcStep = {c[2:0], 1'b0} ^ ((b ^ c[3]) ? CRC_POLY : 4'h0);
  endfunction

  assign sysTimed = select_q[SYNC_SEL_BIT];
  assign serBit   = pinS_q[1];
  assign fSync    = pinS_q[2];
  assign mfSync   = pinS_q[3];

  // Register port: a write lands at once, read data stands one cycle later.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      select_q <= SELECT_RESET;
    end else if (regWr && regAddr == ADDR_SELECT) begin
      select_q <= regWrData;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      rdData_q <= 8'h00;
    end else if (regRd && regAddr == ADDR_SELECT) begin
      rdData_q <= select_q;
    end else if (regRd && regAddr == ADDR_STATUS) begin
      rdData_q <= {timing_q == E1TOM_LOCK, overflow_q, 2'h0, frameIdx_q};
    end else begin
      rdData_q <= 8'h00;
    end
  end
  assign regRdData = rdData_q;

  // A word arriving while the buffer is full is lost; the sticky flag tells software.
  // Writing one to the flag clears it, but a loss in the same cycle wins.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      overflow_q <= 1'b0;
    end else if (pushValid_q && !bufBus.inReady) begin
      overflow_q <= 1'b1;
    end else if (regWr && regAddr == ADDR_STATUS && regWrData[STAT_OVFL_BIT]) begin
      overflow_q <= 1'b0;
    end
  end

  // Pins: three flops each, and a level counts once the last two agree.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      pinA_q <= 4'h0;
      pinB_q <= 4'h0;
      pinC_q <= 4'h0;
      pinS_q <= 4'h0;
    end else begin
      pinA_q <= {tx_multiframe_sync_pin, tx_frame_sync_pin, tx_serial_data_pin,
                 tx_serial_clock_pin};
      pinB_q <= pinA_q;
      pinC_q <= pinB_q;
      pinS_q <= (pinB_q & ~(pinB_q ^ pinC_q)) | (pinS_q & (pinB_q ^ pinC_q));
    end
  end
  assign clkEdge = (pinB_q[0] == pinC_q[0]) && pinC_q[0] && !pinS_q[0];

  // Timing ownership: free running inside, or waiting for and locked to the system side.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      timing_q <= E1TOM_FREE;
    end else begin
      case (timing_q)
        E1TOM_FREE: if (sysTimed) timing_q <= E1TOM_WAIT;
        E1TOM_WAIT: begin
          if (!sysTimed) begin
            timing_q <= E1TOM_FREE;
          end else if (clkEdge && fSync) begin
            timing_q <= E1TOM_LOCK;
          end
        end
        E1TOM_LOCK: if (!sysTimed) timing_q <= E1TOM_FREE;
        default:    timing_q <= E1TOM_FREE;
      endcase
    end
  end
  // Internal timing never waits, even while the state machine is still leaving WAIT.
  assign active = !sysTimed || (timing_q == E1TOM_LOCK) || (clkEdge && fSync);

  always_comb begin
    bitIdx_d   = bitIdx_q + 8'h01;
    frameIdx_d = (bitIdx_q == 8'hFF) ? frameIdx_q + 4'h1 : frameIdx_q;
    if (sysTimed && fSync) begin
      bitIdx_d = 8'h00;
      if (mfSync) begin
        frameIdx_d = 4'h0;
      end else if (bitIdx_q != 8'hFF) begin
        frameIdx_d = frameIdx_q + 4'h1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      bitIdx_q   <= 8'hFF;
      frameIdx_q <= 4'hF;
    end else if (clkEdge && active) begin
      bitIdx_q   <= bitIdx_d;
      frameIdx_q <= frameIdx_d;
    end
  end

  // Overhead source selection for the bit in slot bitIdx_d of frame frameIdx_d.
  always_comb begin
    outBit = serBit;
    if (bitIdx_d[7:3] == 5'h00) begin
      if (!frameIdx_d[0]) begin
        if (bitIdx_d[2:0] == 3'h0) begin
          if (crcMfEnable) begin
            outBit = select_q[CRC_SRC_BIT] ? serBit : crcSend_q[~frameIdx_d[2:1]];
          end else begin
            outBit = select_q[FRAME_SRC_BIT] ? serBit : 1'b1;
          end
        end else begin
          outBit = select_q[FRAME_SRC_BIT] ? serBit : ALIGN_WORD[~bitIdx_d[2:0]];
        end
      end else if (bitIdx_d[2:0] == 3'h0) begin
        if (select_q[FRAME_SRC_BIT]) begin
          outBit = serBit;
        end else if (!crcMfEnable) begin
          outBit = 1'b1;
        end else if (frameIdx_d[3:1] < 3'h6) begin
          outBit = MF_ALIGN[3'h5 - frameIdx_d[3:1]];
        end else begin
          outBit = (select_q[EBIT_SRC_HI:EBIT_SRC_LO] == EBIT_INTERNAL) ? 1'b1 : serBit;
        end
      end else if (bitIdx_d[2:0] == 3'h1) begin
        outBit = select_q[FRAME_SRC_BIT] ? serBit : 1'b1;
      end else if (bitIdx_d[2:0] == 3'h2) begin
        outBit = select_q[FRAME_SRC_BIT] ? serBit : 1'b0;
      end else begin
        case (select_q[DL_SRC_HI:DL_SRC_LO])
          DL_HDLC:     outBit = hdlcBit;
          DL_OVERHEAD: outBit = overheadBit;
          default:     outBit = serBit;
        endcase
      end
    end
  end

  // CRC over each submultiframe with its own C-bit slots counted as zero.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      crc_q     <= 4'h0;
      crcSend_q <= 4'h0;
    end else if (clkEdge && active) begin
      if (bitIdx_d == 8'h00 && frameIdx_d[2:0] == 3'h0) begin
        crcSend_q <= crc_q;
        crc_q     <= crcStep(4'h0, 1'b0);
      end else begin
        crc_q <= crcStep(crc_q, (bitIdx_d == 8'h00 && !frameIdx_d[0]) ? 1'b0 : outBit);
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      pushValid_q <= 1'b0;
      pushData_q  <= '0;
    end else begin
      pushValid_q <= clkEdge && active;
      pushData_q  <= {outBit, bitIdx_d == 8'h00, bitIdx_d == 8'h00 && frameIdx_d == 4'h0};
    end
  end

  // Sync pins are driven only while the framer owns timing.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      syncOe_q    <= 1'b1;
      fSyncOut_q  <= 1'b0;
      mfSyncOut_q <= 1'b0;
    end else begin
      syncOe_q    <= !sysTimed;
      fSyncOut_q  <= clkEdge && active && bitIdx_d == 8'h00;
      mfSyncOut_q <= clkEdge && active && bitIdx_d == 8'h00 && frameIdx_d == 4'h0;
    end
  end
  assign frameSyncOe  = syncOe_q;
  assign mfSyncOe     = syncOe_q;
  assign frameSyncOut = fSyncOut_q;
  assign mfSyncOut    = mfSyncOut_q;

  assign bufBus.inValid  = pushValid_q;
  assign bufBus.inData   = pushData_q;
  assign bufBus.outReady = txBitReady;
  assign txBitValid      = bufBus.outValid;
  assign txBitWord       = bufBus.outData;

  e1tom_two_entry_buf #(.W(BUF_W)) u_buf (
    .core_clk (core_clk),
    .rst      (rst),
    .bus      (bufBus)
  );

  sequence s_sys_sync_edge;
    sysTimed && clkEdge && fSync;
  endsequence

  a_pins_as_inputs: assert property (@(posedge core_clk) disable iff (rst)
    sysTimed ##1 sysTimed |=> !frameSyncOe && !mfSyncOe)
    else $error("Sync pins driven while system side owns timing.");
  a_sync_restarts_frame: assert property (@(posedge core_clk) disable iff (rst)
    s_sys_sync_edge |=> bitIdx_q == 8'h00 && pushValid_q && pushData_q[1])
    else $error("Frame sync did not restart the frame.");
  a_dl_reset_value: assert property (@(posedge core_clk)
    rst |=> select_q[DL_SRC_HI:DL_SRC_LO] == 2'h0)
    else $error("Data link source field not cleared by reset.");
  a_crc_from_serial: assert property (@(posedge core_clk) disable iff (rst)
    clkEdge && active && crcMfEnable && select_q[CRC_SRC_BIT] && bitIdx_d == 8'h00
      && !frameIdx_d[0] |=> pushData_q[2] == $past(serBit))
    else $error("CRC slot did not carry serial data.");
  a_crc_ignored: assert property (@(posedge core_clk) disable iff (rst)
    clkEdge && active && !crcMfEnable && !select_q[FRAME_SRC_BIT] && bitIdx_d == 8'h00
      |=> pushData_q[2])
    else $error("CRC source honoured with CRC multiframe disabled.");
  a_align_word_internal: assert property (@(posedge core_clk) disable iff (rst)
    clkEdge && active && !select_q[FRAME_SRC_BIT] && bitIdx_d == 8'h03 && !frameIdx_d[0]
      |=> pushData_q[2])
    else $error("Alignment word bit wrong.");
  a_ebit_internal: assert property (@(posedge core_clk) disable iff (rst)
    clkEdge && active && crcMfEnable && !select_q[FRAME_SRC_BIT] && bitIdx_d == 8'h00
      && frameIdx_d == 4'hD && select_q[7:6] == 2'h0 |=> pushData_q[2])
    else $error("Internal E bit not sent as one.");
  a_dl_from_hdlc: assert property (@(posedge core_clk) disable iff (rst)
    clkEdge && active && select_q[3:2] == 2'h1 && bitIdx_d == 8'h05 && frameIdx_d[0]
      |=> pushData_q[2] == $past(hdlcBit))
    else $error("Data link bit did not come from HDLC.");
  a_free_running: assert property (@(posedge core_clk) disable iff (rst)
    !sysTimed && clkEdge |=> pushValid_q && syncOe_q)
    else $error("Internal timing skipped a serial edge.");

endmodule

/* File: src/e1tom_pkg.sv */
// Purpose: Constants shared by the transmit overhead source selector.
// Assumes: One 8-bit select register and one status register on a plain port.
// Notes:   Frame and multiframe sizes are the E1 figures.
package e1tom_pkg;

  localparam int          ADDR_W        = 4;
  localparam logic [3:0]  ADDR_SELECT   = 4'h0;
  localparam logic [3:0]  ADDR_STATUS   = 4'h1;

  localparam logic [7:0]  SELECT_RESET  = 8'h00;
  localparam int          EBIT_SRC_HI   = 7;
  localparam int          EBIT_SRC_LO   = 6;
  localparam int          SYNC_SEL_BIT  = 4;
  localparam int          DL_SRC_HI     = 3;
  localparam int          DL_SRC_LO     = 2;
  localparam int          CRC_SRC_BIT   = 1;
  localparam int          FRAME_SRC_BIT = 0;

  localparam int          STAT_LOCK_BIT = 7;
  localparam int          STAT_OVFL_BIT = 6;

  localparam logic [1:0]  DL_SERIAL     = 2'h0;
  localparam logic [1:0]  DL_HDLC       = 2'h1;
  localparam logic [1:0]  DL_OVERHEAD   = 2'h2;
  localparam logic [1:0]  EBIT_INTERNAL = 2'h0;

  localparam logic [7:0]  ALIGN_WORD    = 8'h1B;
  localparam logic [5:0]  MF_ALIGN      = 6'h0B;
  localparam logic [3:0]  CRC_POLY      = 4'h3;

  localparam int          BUF_W         = 3;

  typedef enum logic [1:0] {
    E1TOM_FREE = 2'b00,
    E1TOM_WAIT = 2'b01,
    E1TOM_LOCK = 2'b11
  } e1tom_timing_e;

endpackage

/* File: src/e1tom_buf_if.sv */
// Purpose: Carries outbound bit words into and out of the two-entry buffer.
// Assumes: Valid and ready handshake on both sides, one clock.
// Notes:   Word layout is bit value, frame start, multiframe start.
interface e1tom_buf_if #(parameter int W = 3);
  logic         inValid;
  logic         inReady;
  logic [W-1:0] inData;
  logic         outValid;
  logic         outReady;
  logic [W-1:0] outData;

  modport store (input inValid, input inData, input outReady,
                 output inReady, output outValid, output outData);
  modport user (output inValid, output inData, output outReady,
                input inReady, input outValid, input outData);
endinterface

/* File: src/e1tom_two_entry_buf.sv */
// Purpose: Two-entry buffer whose head word comes straight from a flop; valid is decoded from the entry count.
// Assumes: Synchronous active-high reset.
// Notes:   Entry zero is always the head, so no read pointer is needed.
module e1tom_two_entry_buf
  import e1tom_pkg::*;
#(
  parameter int W = BUF_W
) (
  input wire logic    core_clk,
  input wire logic    rst,
  e1tom_buf_if.store  bus
);

  logic [W-1:0] mem_q [2];
  logic [1:0]   cnt_q;
  logic         pop;
  logic         push;

  assign bus.inReady  = (cnt_q != 2'h2);
  assign push         = bus.inValid && bus.inReady;
  assign pop          = (cnt_q != 2'h0) && bus.outReady;
  assign bus.outValid = (cnt_q != 2'h0);
  assign bus.outData  = mem_q[0];

  always_ff @(posedge core_clk) begin
    if (rst) begin
      cnt_q <= 2'h0;
    end else begin
      cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
    end
  end

  always_ff @(posedge core_clk) begin
    if (pop) begin
      mem_q[0] <= (cnt_q == 2'h2) ? mem_q[1] : bus.inData;
    end else if (push && cnt_q == 2'h0) begin
      mem_q[0] <= bus.inData;
    end
    if (push && ((cnt_q == 2'h1 && !pop) || (cnt_q == 2'h2 && pop))) begin
      mem_q[1] <= bus.inData;
    end
  end

  a_buf_no_overrun: assert property (@(posedge core_clk) disable iff (rst)
    cnt_q == 2'h2 && !pop |=> cnt_q == 2'h2)
    else $error("Buffer count changed while full and not drained.");

endmodule

/* File: sim/e1tom_sys_side.sv */
// Purpose: System-side terminal equipment: serial clock, serial data and sync pins.
// Assumes: The serial clock runs free, as an E1 line clock does.
// Notes:   Syncs are driven only in system mode; data is a level with a mark on sync bits.
module e1tom_sys_side (
  input  wire logic sysMode,
  input  wire logic level,
  output logic      serClk,
  output logic      serData,
  output logic      frameSync,
  output logic      mfSync
);
  timeunit 1ns;
  timeprecision 100ps;

  int   bitCnt = 0;
  int   frmCnt = 0;
  logic fsQ    = 1'h0;
  logic mfQ    = 1'h0;

  initial begin
    serClk    = 1'h0;
    #3;
    forever #80 serClk = ~serClk;
  end

  // Pins move on the falling edge so the device's rising-edge sample sees settled values.
  always @(negedge serClk) begin
    if (!sysMode) begin
      bitCnt    <= 0;
      frmCnt    <= 0;
      fsQ       <= 1'h0;
      mfQ       <= 1'h0;
    end else begin
      fsQ       <= (bitCnt == 0);
      mfQ       <= (bitCnt == 0) && (frmCnt == 0);
      bitCnt    <= (bitCnt == 255) ? 0 : bitCnt + 1;
      if (bitCnt == 255) begin
        frmCnt <= (frmCnt == 15) ? 0 : frmCnt + 1;
      end
    end
  end

  // The mark lets the bench see which bit the device took as the frame's first.
  assign serData   = level ^ fsQ;
  assign frameSync = fsQ;
  assign mfSync    = mfQ;
endmodule

/* File: sim/test_e1_tx_overhead_source_mux.sv */
// Purpose: Register accesses and frame captures that check overhead source selection.
// Assumes: Timeslot 0 bits are the first eight words after each frame start mark.
// Notes:   Frame parity is counted from multiframe start marks in the word stream.
`define CHK(nm, ex, gt) begin samplesChecked++; if ((gt) !== (ex)) begin nFail++; \
  $display("MISMATCH %s expected %h seen %h", nm, ex, gt); end end
module test_e1_tx_overhead_source_mux
  import e1tom_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic              core_clk = 1'h0, rst = 1'h1, regWr = 1'h0, regRd = 1'h0;
  logic              crcMfEnable = 1'h0, hdlcBit = 1'h0, overheadBit = 1'h0;
  logic              txBitReady = 1'h1, sysMode = 1'h0, level = 1'h1;
  logic [ADDR_W-1:0] regAddr = '0;
  logic [7:0]        regWrData = 8'h00, regRdData, rdVal, evenTs, oddTs;
  logic              serClk, serData, fsSys, mfSys, txBitValid;
  logic              frameSyncOut, frameSyncOe, mfSyncOut, mfSyncOe;
  logic [BUF_W-1:0]  txBitWord, heldWord;
  int                nFail = 0, samplesChecked = 0;
  int                idx = 999, frameCnt = 0, starts = 0, fsPulses = 0;
  int                mfPulses = 0, mfStarts = 0;
  wire               fsPin = frameSyncOe ? frameSyncOut : fsSys;
  wire               mfPin = mfSyncOe ? mfSyncOut : mfSys;

  initial begin
    forever #5 core_clk = ~core_clk;
  end

  e1tom_tx_overhead_mux e1tom_tx_overhead_mux_inst (
    .core_clk(core_clk), .rst(rst), .regAddr(regAddr), .regWrData(regWrData),
    .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
    .tx_serial_clock_pin(serClk), .tx_serial_data_pin(serData),
    .tx_frame_sync_pin(fsPin), .tx_multiframe_sync_pin(mfPin),
    .frameSyncOut(frameSyncOut), .frameSyncOe(frameSyncOe),
    .mfSyncOut(mfSyncOut), .mfSyncOe(mfSyncOe), .crcMfEnable(crcMfEnable),
    .hdlcBit(hdlcBit), .overheadBit(overheadBit), .txBitValid(txBitValid),
    .txBitWord(txBitWord), .txBitReady(txBitReady)
  );

  e1tom_sys_side e1tom_sys_side_inst (
    .sysMode(sysMode), .level(level), .serClk(serClk), .serData(serData),
    .frameSync(fsSys), .mfSync(mfSys)
  );

  // Word layout is {bit value, frame start, multiframe start}.
  always @(posedge core_clk) begin
    if (frameSyncOut === 1'h1) fsPulses++;
    if (mfSyncOut === 1'h1) mfPulses++;
    if (txBitValid === 1'h1 && txBitReady === 1'h1) begin
      if (txBitWord[1]) begin
        idx = 0;
        frameCnt = txBitWord[0] ? 0 : frameCnt + 1;
        starts++;
        if (txBitWord[0]) mfStarts++;
      end else begin
        idx++;
      end
      if (idx < 8 && frameCnt[0]) oddTs[idx] = txBitWord[2];
      else if (idx < 8) evenTs[idx] = txBitWord[2];
    end
  end

  task automatic endSim;
    $display("Comparisons %0d, mismatches %0d", samplesChecked, nFail);
    if (nFail == 0 && samplesChecked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    @(posedge core_clk);
    regWr     <= 1'h1;
    regAddr   <= a;
    regWrData <= d;
    @(posedge core_clk);
    regWr <= 1'h0;
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a);
    @(posedge core_clk);
    regRd   <= 1'h1;
    regAddr <= a;
    @(posedge core_clk);
    regRd <= 1'h0;
    #1 rdVal = regRdData;
  endtask

  task automatic waitStarts(input int n);
    int s;
    s = starts + n;
    for (int k = 0; k < 30000 && starts < s; k++) @(posedge core_clk);
    if (starts < s) begin
      nFail++;
      $display("MISMATCH frame start wait ran out");
      endSim();
    end
  endtask

  task automatic cfg(input logic [7:0] sel, input logic lv, cr, hd, oh);
    @(posedge core_clk);
    level       <= lv;
    crcMfEnable <= cr;
    hdlcBit     <= hd;
    overheadBit <= oh;
    wr(ADDR_SELECT, sel);
    rd(ADDR_SELECT);
    `CHK("select readback", sel, rdVal)
    waitStarts(3);
  endtask

  initial begin
    repeat (2) @(posedge core_clk);
    rst <= 1'h0;
    @(posedge core_clk);
    rd(ADDR_SELECT);
    `CHK("select reset", SELECT_RESET, rdVal)
    `CHK("sync oe internal", 1'h1, frameSyncOe)
    rd(4'hF);
    `CHK("unmapped read", 8'h00, rdVal)
    cfg(8'h00, 1'h1, 1'h0, 1'h0, 1'h0);
    `CHK("even ts0 internal", 8'hD9, evenTs)
    `CHK("odd ts0 serial link", 7'h7D, oddTs[7:1])
    `CHK("sync pulses", 1'h1, (fsPulses >= starts && fsPulses <= starts + 1))
    `CHK("mf sync pulses", 1'h1, (mfPulses >= mfStarts && mfPulses <= mfStarts + 1))
    cfg(8'h06, 1'h0, 1'h1, 1'h1, 1'h0);
    `CHK("crc from serial", 1'h0, evenTs[0])
    `CHK("link from hdlc", 7'h7D, oddTs[7:1])
    cfg(8'h08, 1'h1, 1'h0, 1'h1, 1'h0);
    `CHK("link from overhead", 5'h00, oddTs[7:3])
    cfg(8'h02, 1'h0, 1'h0, 1'h0, 1'h0);
    `CHK("crc select ignored", 1'h1, evenTs[0])
    cfg(8'h01, 1'h0, 1'h0, 1'h0, 1'h0);
    `CHK("even ts0 serial", 8'h00, evenTs)
    // The equipment starts its syncs only once the device listens to them.
    wr(ADDR_SELECT, 8'h11);
    @(posedge core_clk);
    sysMode <= 1'h1;
    waitStarts(3);
    `CHK("frame sync oe", 1'h0, frameSyncOe)
    `CHK("mf sync oe", 1'h0, mfSyncOe)
    `CHK("frame follows sync", 8'h01, evenTs)
    txBitReady <= 1'h0;
    repeat (100) @(posedge core_clk);
    #1 heldWord = txBitWord;
    `CHK("stalled valid", 1'h1, txBitValid)
    repeat (50) @(posedge core_clk);
    #1;
    `CHK("stalled word", heldWord, txBitWord)
    rd(ADDR_STATUS);
    `CHK("overflow set", 1'h1, rdVal[STAT_OVFL_BIT])
    `CHK("locked to system sync", 1'h1, rdVal[STAT_LOCK_BIT])
    @(posedge core_clk);
    txBitReady <= 1'h1;
    repeat (60) @(posedge core_clk);
    wr(ADDR_STATUS, 8'h40);
    rd(ADDR_STATUS);
    `CHK("overflow cleared", 1'h0, rdVal[STAT_OVFL_BIT])
    endSim();
  end
endmodule
